// >>> hdl/arc_regs.vh
/*
  Register map, field positions, value limits and timing figures of the analog
  ramp controller. Assumes inclusion by bare name from the design file.
*/
`ifndef ARC_REGS_VH
`define ARC_REGS_VH
// byte offsets on the AHB-Lite register bus
`define ARC_ADDR_CTRL 8'h00
`define ARC_ADDR_LVL1 8'h04
`define ARC_ADDR_LVL2 8'h08
`define ARC_ADDR_CEIL 8'h0c
`define ARC_ADDR_START_STOP_OFFSET 8'h10
`define ARC_ADDR_RATE 8'h14
`define ARC_ADDR_GAIN 8'h18
`define ARC_ADDR_OFFS 8'h1c
`define ARC_ADDR_SRC 8'h20
`define ARC_ADDR_STAT 8'h24
`define ARC_ADDR_CUR 8'h28
`define ARC_ADDR_AQ 8'h2c
// control bits
`define ARC_CTRL_EN 0
`define ARC_CTRL_SEL 1
`define ARC_CTRL_STOP 2
// source register fields
`define ARC_SRC_USE1 16
`define ARC_SRC_USE2 17
// limits, 18-bit signed; then the 32-bit output limit and the 32-bit and 16-bit scale factors
`define ARC_LVL_MIN 18'sh3d8f0
`define ARC_LVL_MAX 18'sh04e20
`define ARC_OFFS_MIN 18'sh3d8f0
`define ARC_OFFS_MAX 18'sh02710
`define ARC_START_STOP_OFFSET_MIN 18'sh00000
`define ARC_RATE_MIN 18'sh00001
`define ARC_RATE_MAX 18'sh02710
`define ARC_GAIN_MAX 18'sh003e8
`define ARC_AQ_MAX 32'h00007fff
`define ARC_GAIN_UNIT 32'h00000064
`define ARC_RATE_DIV 16'h000a
// reset values
`define ARC_RST_CEIL 16'h4e20
`define ARC_RST_RATE 16'h000a
`define ARC_RST_GAIN 16'h0064
// timing: update period in ms and clock rate in kHz
`define ARC_TICK_MS 100
`define ARC_CLK_KHZ 250000
`endif

// >>> hdl/arc_ramp.v
/*
  Analog ramp controller with an AHB-Lite register slave, a 100 ms update
  tick, a ramp state machine and the scaled analog output.
  Assumes a single AHB-Lite master, word transfers and one clock domain.
*/
// Chosen here: register access over AHB-Lite and the register offsets.
// Functional notes
// - enable rise forces offset plus start/stop offset, held 100 ms
// - after that hold, ramp toward the selected target at the rate
// - select low picks first target, high picks second target
// - select change ramps smoothly from present level to new target
// - stop rise ramps level down to the start/stop level
// - start/stop level is held for 100 ms after a stop
// - after that hold, level becomes offset and output zero
// - after a stop, no restart until stop and enable are low
// - enable fall sets level to offset at once, no ramp
// - current level recomputed only on the 100 ms tick; here the ceiling clips it on every clock
// - output equals level minus offset divided by gain
// - output limited to zero through 32767
// - current level never exceeds the level ceiling
// - target levels accepted in range -10000 to +20000
// - start/stop offset accepted from 0 to +20000
// - rate is steps per second, accepted 1 to 10000; here rate/10 steps per tick, rounded down, at least one
// - gain 0 to 10.00 in hundredths, offset within +-10000
// - targets may come from another block chosen by number
`include "arc_regs.vh"

module arc_ramp #(
  parameter integer TICK_CYCLES = `ARC_TICK_MS * `ARC_CLK_KHZ
) (
  // clock and reset
  input wire CLK,
  input wire NRST,
  // ahb-lite slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire HREADYOUT,
  output wire HRESP,
  output wire [31:0] HRDATA,
  // external target sources
  input wire [15:0] EXT_FIRST_TARGET_LEVEL,
  input wire [15:0] EXT_SECOND_TARGET_LEVEL,
  output wire [7:0] SRC_BLOCK1,
  output wire [7:0] SRC_BLOCK2,
  // analog result
  output wire [15:0] SCALED_ANALOG_OUTPUT,
  output wire [15:0] CURRENT_LEVEL
);

////////////////////////////////////////////////////////////////////////////////
localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
localparam [5:0] S_IDLE = 6'h01;
localparam [5:0] S_HOLD1 = 6'h02;
localparam [5:0] S_RUN = 6'h04;
localparam [5:0] S_DECEL = 6'h08;
localparam [5:0] S_HOLD2 = 6'h10;
localparam [5:0] S_LOCK = 6'h20;

function signed [17:0] sx;
  input [15:0] v;
  begin
    sx = {{2{v[15]}}, v};
  end
endfunction

function signed [17:0] clip;
  input signed [17:0] v;
  input signed [17:0] lo;
  input signed [17:0] hi;
  begin
    if (v < lo) begin
      clip = lo;
    end else if (v > hi) begin
      clip = hi;
    end else begin
      clip = v;
    end
  end
endfunction

// one step toward the target, landing on it exactly
function signed [17:0] move;
  input signed [17:0] cur;
  input signed [17:0] tgt;
  input signed [17:0] step;
  begin
    if (cur < tgt) begin
      move = (tgt - cur <= step) ? tgt : cur + step;
    end else if (cur > tgt) begin
      move = (cur - tgt <= step) ? tgt : cur - step;
    end else begin
      move = cur;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// bus registers
reg [2:0] ctrl_r;
reg [15:0] lvl1_r;
reg [15:0] lvl2_r;
reg [15:0] ceil_r;
reg [15:0] start_stop_offset_r;
reg [15:0] rate_r;
reg [15:0] gain_r;
reg [15:0] offs_r;
reg [17:0] src_r;
reg [7:0] waddr_r;
reg wr_pend_r;
reg [31:0] rdata_r;
// ramp state
reg [5:0] state_r;
reg [5:0] state_nxt;
reg signed [17:0] level_r;
reg signed [17:0] level_nxt;
reg [31:0] tick_cnt_r;
reg restart;
reg en_q_r;
reg st_q_r;
reg [15:0] aq_r;
reg [31:0] rd_mux;

wire [7:0] a_addr = HADDR[7:0];
wire a_take = HSEL & HREADY & HTRANS[1];
wire signed [17:0] wv = sx(HWDATA[15:0]);

assign HREADYOUT = 1'b1;
assign HRESP = 1'b0;
assign HRDATA = rdata_r;
assign SRC_BLOCK1 = src_r[7:0];
assign SRC_BLOCK2 = src_r[15:8];
assign SCALED_ANALOG_OUTPUT = aq_r;
assign CURRENT_LEVEL = level_r[15:0];

////////////////////////////////////////////////////////////////////////////////
// read data is latched in the address phase so it stands from a flip-flop
always @* begin
  rd_mux = 32'h00000000;
  case (a_addr)
    `ARC_ADDR_CTRL: rd_mux = {29'h0, ctrl_r};
    `ARC_ADDR_LVL1: rd_mux = {16'h0, lvl1_r};
    `ARC_ADDR_LVL2: rd_mux = {16'h0, lvl2_r};
    `ARC_ADDR_CEIL: rd_mux = {16'h0, ceil_r};
    `ARC_ADDR_START_STOP_OFFSET: rd_mux = {16'h0, start_stop_offset_r};
    `ARC_ADDR_RATE: rd_mux = {16'h0, rate_r};
    `ARC_ADDR_GAIN: rd_mux = {16'h0, gain_r};
    `ARC_ADDR_OFFS: rd_mux = {16'h0, offs_r};
    `ARC_ADDR_SRC: rd_mux = {14'h0, src_r};
    // status, level and output are read only; writes to them are dropped
    `ARC_ADDR_STAT: rd_mux = {26'h0, state_r};
    `ARC_ADDR_CUR: rd_mux = {16'h0, level_r[15:0]};
    `ARC_ADDR_AQ: rd_mux = {16'h0, aq_r};
    default: rd_mux = 32'h00000000;
  endcase
end

// clipped copies of the write data, one per value range
wire signed [17:0] wv_lvl = clip(wv, `ARC_LVL_MIN, `ARC_LVL_MAX);
wire signed [17:0] wv_start_stop_offset = clip(wv, `ARC_START_STOP_OFFSET_MIN, `ARC_LVL_MAX);
wire signed [17:0] wv_rate = clip(wv, `ARC_RATE_MIN, `ARC_RATE_MAX);
wire signed [17:0] wv_gain = clip(wv, `ARC_START_STOP_OFFSET_MIN, `ARC_GAIN_MAX);
wire signed [17:0] wv_offs = clip(wv, `ARC_OFFS_MIN, `ARC_OFFS_MAX);

// out-of-range writes are pinned to the nearest legal value
always @(posedge CLK or negedge NRST) begin
  if (!NRST) begin
    wr_pend_r <= 1'b0;
    waddr_r <= 8'h00;
    rdata_r <= 32'h00000000;
    ctrl_r <= 3'h0;
    lvl1_r <= 16'h0000;
    lvl2_r <= 16'h0000;
    ceil_r <= `ARC_RST_CEIL;
    start_stop_offset_r <= 16'h0000;
    rate_r <= `ARC_RST_RATE;
    gain_r <= `ARC_RST_GAIN;
    offs_r <= 16'h0000;
    src_r <= 18'h00000;
  end else begin
    wr_pend_r <= a_take & HWRITE;
    if (a_take) begin
      waddr_r <= a_addr;
      rdata_r <= HWRITE ? 32'h00000000 : rd_mux;
    end
    if (wr_pend_r) begin
      case (waddr_r)
        `ARC_ADDR_CTRL: ctrl_r <= HWDATA[2:0];
        `ARC_ADDR_LVL1: lvl1_r <= wv_lvl[15:0];
        `ARC_ADDR_LVL2: lvl2_r <= wv_lvl[15:0];
        `ARC_ADDR_CEIL: ceil_r <= wv_lvl[15:0];
        `ARC_ADDR_START_STOP_OFFSET: start_stop_offset_r <= wv_start_stop_offset[15:0];
        `ARC_ADDR_RATE: rate_r <= wv_rate[15:0];
        `ARC_ADDR_GAIN: gain_r <= wv_gain[15:0];
        `ARC_ADDR_OFFS: offs_r <= wv_offs[15:0];
        `ARC_ADDR_SRC: src_r <= HWDATA[17:0];
        default: ;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// effective parameters
wire en = ctrl_r[`ARC_CTRL_EN];
wire st = ctrl_r[`ARC_CTRL_STOP];
wire en_rise = en & ~en_q_r;
wire en_fall = ~en & en_q_r;
wire st_rise = st & ~st_q_r;
// outside values are clipped like written targets
wire signed [17:0] ext1 = clip(sx(EXT_FIRST_TARGET_LEVEL), `ARC_LVL_MIN, `ARC_LVL_MAX);
wire signed [17:0] ext2 = clip(sx(EXT_SECOND_TARGET_LEVEL), `ARC_LVL_MIN, `ARC_LVL_MAX);
wire signed [17:0] tgt1 = src_r[`ARC_SRC_USE1] ? ext1 : sx(lvl1_r);
wire signed [17:0] tgt2 = src_r[`ARC_SRC_USE2] ? ext2 : sx(lvl2_r);
wire signed [17:0] tgt = ctrl_r[`ARC_CTRL_SEL] ? tgt2 : tgt1;
wire signed [17:0] offs = sx(offs_r);
wire signed [17:0] ceil = sx(ceil_r);
wire signed [17:0] ss_lvl = offs + sx(start_stop_offset_r);
wire [15:0] step_q = rate_r / `ARC_RATE_DIV;
// rates under ten would never move at one tenth; they move one step per tick
wire [15:0] step_u = (step_q == 16'h0000) ? 16'h0001 : step_q;
wire signed [17:0] step = {2'b00, step_u};
// the tick runs free; only an enable rise realigns it
wire tick = (tick_cnt_r == TICK_LAST);
// decel never climbs: a level under the start/stop level snaps to it
wire signed [17:0] down = (level_r <= ss_lvl) ? ss_lvl : move(level_r, ss_lvl, step);

////////////////////////////////////////////////////////////////////////////////
// ramp state machine
always @* begin
  state_nxt = state_r;
  level_nxt = level_r;
  restart = 1'b0;
  case (state_r)
    S_IDLE: begin
      level_nxt = offs;
      if (en_rise) begin
        level_nxt = ss_lvl;
        restart = 1'b1;
        state_nxt = S_HOLD1;
      end
    end
    S_HOLD1: begin
      // a stop during the start hold decelerates from the start/stop level
      if (st_rise) begin
        state_nxt = S_DECEL;
      end else if (tick) begin
        level_nxt = move(level_r, tgt, step);
        state_nxt = S_RUN;
      end
    end
    S_RUN: begin
      if (st_rise) begin
        state_nxt = S_DECEL;
      end else if (tick) begin
        // target follows select, so a change ramps from where it stands
        level_nxt = move(level_r, tgt, step);
      end
    end
    S_DECEL: begin
      if (tick) begin
        level_nxt = down;
        if (down == ss_lvl) begin
          state_nxt = S_HOLD2;
        end
      end
    end
    S_HOLD2: begin
      if (tick) begin
        level_nxt = offs;
        state_nxt = S_LOCK;
      end
    end
    S_LOCK: begin
      level_nxt = offs;
      if (!en && !st) begin
        state_nxt = S_IDLE;
      end
    end
    default: begin
      state_nxt = S_IDLE;
      level_nxt = offs;
    end
  endcase
  // enable fall overrides every state; a stop under way stays locked
  if (en_fall) begin
    level_nxt = offs;
    if (state_r == S_DECEL || state_r == S_HOLD2 || state_r == S_LOCK) begin
      state_nxt = S_LOCK;
    end else begin
      state_nxt = S_IDLE;
    end
  end
  // the ceiling acts on every edge, so lowering it pulls the level at once
  if (level_nxt > ceil) begin
    level_nxt = ceil;
  end
end

// the tick restarts on enable so the start hold is one full period
always @(posedge CLK or negedge NRST) begin
  if (!NRST) begin
    tick_cnt_r <= 32'h00000000;
    state_r <= S_IDLE;
    level_r <= 18'sh00000;
    en_q_r <= 1'b0;
    st_q_r <= 1'b0;
  end else begin
    if (restart || tick) begin
      tick_cnt_r <= 32'h00000000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
    end
    state_r <= state_nxt;
    level_r <= level_nxt;
    en_q_r <= en;
    st_q_r <= st;
  end
end

////////////////////////////////////////////////////////////////////////////////
// scaled output; gain is in hundredths, zero gain saturates a positive value
// division truncates; the output trails the level by one clock
wire signed [17:0] diff = level_r - offs;
wire [31:0] num = {14'h0000, diff} * `ARC_GAIN_UNIT;
wire [31:0] quo = (gain_r == 16'h0000) ? `ARC_AQ_MAX : num / {16'h0000, gain_r};

always @(posedge CLK or negedge NRST) begin
  if (!NRST) begin
    aq_r <= 16'h0000;
  end else if (diff <= 18'sh00000) begin
    aq_r <= 16'h0000;
  end else if (quo > `ARC_AQ_MAX) begin
    aq_r <= 16'h7fff;
  end else begin
    aq_r <= quo[15:0];
  end
end

endmodule // arc_ramp

// >>> testbench/arc_src_model.sv
/* model of the neighbouring function blocks that supply target values
   assumes the ramp picks its source block by number */
module arc_src_model (
  // block numbers asked for
  input wire logic [7:0] blk1,
  input wire logic [7:0] blk2,
  // values of those blocks
  output logic [15:0] val1,
  output logic [15:0] val2
);
  timeunit 1ns;
  timeprecision 1ps;
  // value is the block number times 100, so a wrong block is visible
  assign val1 = {8'h00, blk1} * 16'h0064;
  assign val2 = {8'h00, blk2} * 16'h0064;
endmodule // arc_src_model

// >>> testbench/arc_ramp_monitor.sv
/* port checker for the ramp controller
   assumes it is bound onto arc_ramp, one clock domain */
module arc_ramp_mon #(
  parameter integer TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  // results
  input wire logic [7:0] SRC_BLOCK1,
  input wire logic [7:0] SRC_BLOCK2,
  input wire logic [15:0] SCALED_ANALOG_OUTPUT,
  input wire logic [15:0] CURRENT_LEVEL
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc, lchg, achg, wdp_r;
  logic [7:0] wgap_r;
  logic [31:0] lgap_r;
  logic [15:0] lvl_r, aq_r;
  assign acc = HSEL & HREADY & HTRANS[1];
  assign lchg = CURRENT_LEVEL != lvl_r;
  assign achg = SCALED_ANALOG_OUTPUT != aq_r;
  //////////////////////////////////////////
  // gaps since the last landed write and the last level move
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wdp_r <= 1'b0;
      wgap_r <= 8'hff;
      lgap_r <= 32'h0;
      lvl_r <= 16'h0;
      aq_r <= 16'h0;
    end else begin
      wdp_r <= acc & HWRITE;
      wgap_r <= wdp_r ? 8'h00 : wgap_r + {7'h0, wgap_r != 8'hff};
      lgap_r <= lchg ? 32'h0 : lgap_r + 32'h1;
      lvl_r <= CURRENT_LEVEL;
      aq_r <= SCALED_ANALOG_OUTPUT;
    end
  end
  //////////////////////////////////////////
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  chk_ready_high: assert property (HREADYOUT)
    else $error("ready low");
  chk_resp_okay: assert property (!HRESP)
    else $error("error response");
  chk_aq_range: assert property (!SCALED_ANALOG_OUTPUT[15])
    else $error("output above range");
  chk_rdata_hold: assert property (!$past(acc) |-> $stable(HRDATA))
    else $error("read data moved");
  chk_rdata_wr: assert property (wdp_r |-> HRDATA == 32'h0)
    else $error("read data in write");
  chk_src_cause: assert property ($changed({SRC_BLOCK1, SRC_BLOCK2}) |-> wgap_r < 8'h02)
    else $error("source moved alone");
  chk_aq_cause: assert property (achg |-> $past(lchg) || wgap_r < 8'h08)
    else $error("output moved alone");
  // a move far from a write must be a whole update period after the last
  chk_lvl_tick: assert property (lchg |-> wgap_r < 8'h08 || lgap_r >= TICK_CYCLES - 2)
    else $error("level off tick");
  cov_step: cover property (lchg && lgap_r >= TICK_CYCLES - 2);
  cov_src: cover property ($changed(SRC_BLOCK1));
  cov_aq: cover property (SCALED_ANALOG_OUTPUT != 16'h0);
endmodule // arc_ramp_mon
bind arc_ramp arc_ramp_mon #(.TICK_CYCLES(TICK_CYCLES)) i_arc_ramp_mon (
  .CLK, .NRST, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRESP, .HRDATA,
  .SRC_BLOCK1, .SRC_BLOCK2, .SCALED_ANALOG_OUTPUT, .CURRENT_LEVEL
);

// >>> testbench/arc_ramp_tb_top.sv
/* self-checking bench for the ramp controller over its register bus
   assumes the checker is bound in and a short update period */
module arc_ramp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer T = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  wire hrdy;
  wire [31:0] hrdata;
  wire [15:0] ext1, ext2, aq, cur;
  wire [7:0] blk1, blk2;
  wire [31:0] curx = {16'h0, cur};
  wire [31:0] aqx = {16'h0, aq};
  int mismatches = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] ca [8] = '{8'h04, 8'h04, 8'h10, 8'h14, 8'h14, 8'h18, 8'h1c, 8'h28};
  logic [31:0] cd [8] = '{32'h7530, 32'hb1e0, 32'hfffb, 32'h0, 32'h4e20, 32'h7d0,
    32'h3a98, 32'h1234};
  logic [31:0] ce [8] = '{32'h4e20, 32'hd8f0, 32'h0, 32'h1, 32'h2710, 32'h3e8,
    32'h2710, 32'h2710};
  logic [7:0] sa [7] = '{8'h1c, 8'h18, 8'h10, 8'h14, 8'h04, 8'h20, 8'h00};
  logic [31:0] sd [7] = '{32'h0, 32'd100, 32'd100, 32'd1000, 32'h0, 32'h10005, 32'h1};
  always #2 clk = ~clk;
  //////////////////////////////////////////
  arc_ramp #(.TICK_CYCLES(T)) i_arc_ramp (
    .CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hrdy),
    .HREADYOUT(hrdy), .HRESP(), .HRDATA(hrdata), .EXT_FIRST_TARGET_LEVEL(ext1),
    .EXT_SECOND_TARGET_LEVEL(ext2), .SRC_BLOCK1(blk1), .SRC_BLOCK2(blk2),
    .SCALED_ANALOG_OUTPUT(aq), .CURRENT_LEVEL(cur)
  );
  arc_src_model i_arc_src_model (.blk1(blk1), .blk2(blk2), .val1(ext1), .val2(ext2));
  //////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wl(input logic [15:0] v);
    n = 0;
    while (cur !== v && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk(curx, {16'h0, v});
  endtask
  // cycles the level stays at v once reached
  task automatic hm(input logic [15:0] v);
    wl(v);
    n = 0;
    while (cur === v && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= T - 2 && n <= T + 2}, 32'h1);
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////
  initial begin
    #100us;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rc(8'h0c, 32'h4e20);
    rc(8'h14, 32'h000a);
    rc(8'h24, 32'h0001);
    rc(8'h30, 32'h0);
    // out-of-range writes clip to the nearest limit; a write to the read-only level is dropped
    foreach (ca[i]) begin
      xfer(1'b1, ca[i], cd[i]);
      rc(ca[i], ce[i]);
    end
    tdone("regs");
    foreach (sa[i]) xfer(1'b1, sa[i], sd[i]);
    chk({24'h0, blk1}, 32'h5);
    chk({24'h0, blk2}, 32'h0);
    hm(16'd100);
    chk(curx, 32'd200);
    wl(16'd500);
    repeat (2 * T) @(posedge clk);
    chk(curx, 32'd500);
    chk(aqx, 32'd500);
    xfer(1'b1, 8'h18, 32'd200);
    repeat (3) @(posedge clk);
    chk(aqx, 32'd250);
    tdone("ramp");
    xfer(1'b1, 8'h08, 32'd250);
    xfer(1'b1, 8'h00, 32'h3);
    while (cur === 16'd500) @(posedge clk);
    chk(curx, 32'd400);
    wl(16'd250);
    xfer(1'b1, 8'h0c, 32'd200);
    wl(16'd200);
    repeat (2 * T) @(posedge clk);
    chk(curx, 32'd200);
    xfer(1'b1, 8'h0c, 32'h4e20);
    tdone("select");
    xfer(1'b1, 8'h00, 32'h7);
    hm(16'd100);
    chk(curx, 32'd0);
    rc(8'h24, 32'h20);
    // stop released but enable still high must not restart
    xfer(1'b1, 8'h00, 32'h1);
    repeat (3 * T) @(posedge clk);
    chk(curx, 32'd0);
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b1, 8'h00, 32'h1);
    wl(16'd300);
    xfer(1'b1, 8'h20, 32'h30205);
    xfer(1'b1, 8'h00, 32'h3);
    chk({24'h0, blk2}, 32'h2);
    wl(16'd200);
    xfer(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge clk);
    chk(curx, 32'd0);
    chk(aqx, 32'd0);
    tdone("stop");
    print_verdict();
  end
endmodule // arc_ramp_tb_top
